// ==== verilog/rsh_rx_sig_highway_regs.vh ====
// Purpose: constants of the signaling highway block
// Assumes: plain Verilog-2005, included by bare name
// Notes on behaviour
// - flags, crc, address, zero removal
// - one or two byte address
// - c/r bit ignored in two byte match
// - 64 byte receive fifo
// - transparent skips framing
// - robbed bit each sixth frame
// - signaling aligned to data
// - superframe repeats a as c; d sent as one
// - bits 1-4 forced; idle none
// - all ones on both outputs
// - auto freeze unless disabled
// - change irq and pointer
// - receivers enabled, auto switching
// - codeword leftmost bit first
// - filter needs 7 of 10
// - f72 data link to fifo
// - clock rate >= data rate
// - selected edge and phase
// - frame start sync plus offset
// - frame marker one base bit
// - multiplex interleave rate limits
`ifndef RSH_RX_SIG_HIGHWAY_REGS_VH
`define RSH_RX_SIG_HIGHWAY_REGS_VH
`define RSH_FLAG 8'h7e
`define RSH_GRP_FE 8'hfe
`define RSH_GRP_FC 8'hfc
`define RSH_CR_MASK 8'hfd
`define RSH_CRC_INIT 16'hffff
`define RSH_CRC_POLY 16'h8408
`define RSH_CRC_GOOD 16'hf0b8
`define RSH_FIFO_DEPTH 64
`define RSH_FIFO_AW 6
`define RSH_BOM_WIN 4'h9
`define RSH_BOM_NEED 4'h7
`define RSH_DL_FIRST 7'h1a
`define RSH_DL_LAST 7'h48
`define RSH_CAS_ROWS 7'h60
`define RSH_SIG_TS_MAX 5'h17
`define RSH_PIN_MARKER 3'h1
`define RSH_FLAG_SKIP 4'h8
`endif

// ==== verilog/rsh_rx_sig_highway.v ====
// Purpose: receive signaling and highway of one channel
// Assumes: line side on clk; highway and signaling pins asynchronous
// Notes: highway clock is oversampled; keep it far below 125 MHz
`timescale 1ns/100ps
`default_nettype none
`include "rsh_rx_sig_highway_regs.vh"

module rsh_fifo #(parameter W = 8, parameter D = 64, parameter AW = 6)
(
  input wire clk, // core clock
  input wire sys_rst, // synchronous reset
  input wire in_valid, // write request
  output wire in_ready, // not full
  input wire [W-1:0] in_data, // write data
  output wire out_valid, // not empty
  input wire out_ready, // read accept
  output wire [W-1:0] out_data // head word
);
  reg [W-1:0] mem_reg [0:D-1];
  reg [AW-1:0] wp_reg;
  reg [AW-1:0] rp_reg;
  reg [AW:0] cnt_reg;
  wire do_wr = in_valid & in_ready;
  wire do_rd = out_valid & out_ready;
  assign in_ready = (cnt_reg != D);
  assign out_valid = (cnt_reg != 0);
  assign out_data = mem_reg[rp_reg];
  always @(posedge clk)
  begin
    if (do_wr)
      mem_reg[wp_reg] <= in_data;
    if (sys_rst)
    begin
      wp_reg <= {AW{1'b0}};
      rp_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_wr)
        wp_reg <= wp_reg + 1'b1;
      if (do_rd)
        rp_reg <= rp_reg + 1'b1;
      if (do_wr & ~do_rd)
        cnt_reg <= cnt_reg + 1'b1;
      else if (do_rd & ~do_wr)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end
endmodule

module rsh_rx_sig_highway
(
  input wire clk, // core clock 250 MHz
  input wire sys_rst, // synchronous reset, high
  input wire line_bit, // received line bit
  input wire line_bit_en, // line bit strobe
  input wire [4:0] line_ts, // time slot of line bit
  input wire [2:0] line_bitpos, // bit position, 7 = lsb
  input wire [6:0] line_frame, // frame number in multiframe, from 1
  input wire sig_slot, // bit belongs to signaling controller
  input wire dl_bit, // bit is a data link bit
  input wire esf_format, // esf multiframe
  input wire f72_format, // f72 multiframe
  input wire los, // loss of signal
  input wire lfa, // loss of frame alignment
  input wire rx_slip, // receive slip pulse
  input wire hdlc_receiver_on, // hdlc receiver enable
  input wire message_receiver_on, // message receiver enable
  input wire transparent_mode, // no hdlc framing
  input wire addr_two_byte, // two byte address mode
  input wire [7:0] high_address_match_1, // programmable high address 1
  input wire [7:0] high_address_match_2, // programmable high address 2
  input wire [1:0] message_receive_mode, // 0 all, 1 changes, 2 none
  input wire message_filter_enable, // 7 of 10 filter
  input wire auto_freeze_disable, // no automatic freeze
  input wire ext_signaling_en, // signaling from system pin
  input wire system_signaling_in, // system signaling pin
  input wire send_all_ones_system, // all ones to system
  input wire sig_fix_en, // force first four bits
  input wire sig_fix_val, // forced level
  input wire irq_status_read, // status read pulse
  input wire [3:0] sig_rd_index, // signaling register select
  output reg [7:0] sig_rd_data, // selected signaling register
  output reg freeze_indicator_pin, // freeze pin
  output wire freeze_status_flag, // freeze status
  output reg signaling_change_irq, // signaling change pending
  output reg [3:0] signaling_change_pointer, // changed register
  output reg [23:0] dl_bit_regs, // data link bits of multiframe
  output wire fifo_out_valid, // receive fifo not empty
  input wire fifo_out_ready, // receive fifo read
  output wire [7:0] fifo_out_data, // receive fifo head
  input wire receive_highway_clock, // highway clock pin
  input wire receive_sync_pulse, // sync pulse pin, low active
  input wire highway_edge_select, // 1 falling edge
  input wire [1:0] highway_clock_rate_low, // clock rate code
  input wire highway_clock_rate_high, // top clock rate
  input wire highway_data_rate_high, // data rate code msb
  input wire highway_data_rate_low, // data rate code lsb
  input wire [2:0] channel_phase_select, // active phase
  input wire [7:0] receive_offset_low, // offset low byte
  input wire [3:0] receive_offset_high, // offset high bits
  input wire [2:0] receive_pin_function, // pin function
  input wire multiplex_mode, // four channel multiplex
  input wire byte_interleave, // multiplex byte interleave
  input wire [7:0] highway_byte, // byte of highway_ts
  input wire highway_ts_idle, // highway_ts unequipped
  output wire [4:0] highway_ts, // time slot being sent
  output reg receive_data_out, // highway data
  output reg receive_signaling_out, // highway signaling
  output reg receive_frame_marker, // frame marker
  output wire rate_valid // rate combination valid
);
  // synchronisers for asynchronous pins
  reg hc_s1, hc_s2, hc_s3, sp_s1, sp_s2, sp_s3, ss_s1, ss_s2;
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      hc_s1 <= 1'b0;
      hc_s2 <= 1'b0;
      hc_s3 <= 1'b0;
      sp_s1 <= 1'b1;
      sp_s2 <= 1'b1;
      sp_s3 <= 1'b1;
      ss_s1 <= 1'b0;
      ss_s2 <= 1'b0;
    end
    else
    begin
      hc_s1 <= receive_highway_clock;
      hc_s2 <= hc_s1;
      hc_s3 <= hc_s2;
      sp_s1 <= receive_sync_pulse;
      sp_s2 <= sp_s1;
      sp_s3 <= sp_s2;
      ss_s1 <= system_signaling_in;
      ss_s2 <= ss_s1;
    end
  end

  // hdlc / transparent / message receiver
  function [15:0] crc_step;
    input [15:0] c;
    input b;
    begin
      crc_step = (c >> 1) ^ ((c[0] ^ b) ? `RSH_CRC_POLY : 16'h0000);
    end
  endfunction

  wire hb_en = line_bit_en & sig_slot & ~(f72_format & dl_bit);
  reg [7:0] hsh_reg, bsr_reg;
  reg [15:0] crc_reg, msh_reg;
  reg [2:0] ones_reg, bcnt_reg;
  reg [3:0] skip_reg, run_reg;
  reg [1:0] bytes_reg;
  reg in_frame_reg, addr_ok_reg, bom_reg;
  wire [7:0] hsh_next = {line_bit, hsh_reg[7:1]};
  wire [15:0] msh_next = {msh_reg[14:0], line_bit};
  wire hdlc_act = hdlc_receiver_on & ~bom_reg;
  wire flag_seen = hdlc_act & ~transparent_mode & (hsh_next == `RSH_FLAG);
  wire abort_seen = hsh_next[7:1] == 7'h7f;
  wire b_old = hsh_reg[0];
  wire stuffed = (ones_reg == 3'h5) & ~b_old;
  wire dv = hdlc_act & (transparent_mode | (in_frame_reg & (skip_reg == 4'h0) & ~stuffed));
  wire dbit = transparent_mode ? line_bit : b_old;
  wire [15:0] crc_upd = dv ? crc_step(crc_reg, dbit) : crc_reg;
  wire [7:0] byte_new = {dbit, bsr_reg[7:1]};
  wire [7:0] hi_m = byte_new & `RSH_CR_MASK;
  wire hi_ok = (hi_m == (`RSH_GRP_FE & `RSH_CR_MASK)) | (hi_m == (`RSH_GRP_FC & `RSH_CR_MASK)) |
    (hi_m == (high_address_match_1 & `RSH_CR_MASK)) | (hi_m == (high_address_match_2 & `RSH_CR_MASK));
  wire one_ok = (byte_new == high_address_match_1) | (byte_new == high_address_match_2);
  wire byte_done = hb_en & dv & (bcnt_reg == 3'h7);
  wire addr_now = addr_two_byte ? hi_ok : one_ok;
  wire byte_keep = transparent_mode | ((bytes_reg == 2'h0) ? addr_now : addr_ok_reg);
  wire cw_seen = bom_reg & (msh_next[15:7] == 9'h1fe) & ~msh_next[0];
  wire [5:0] cw = msh_next[6:1];

  // pending fifo words, one source granted per cycle
  reg byte_pend, st_pend, bom_pend, dl_pend;
  reg [7:0] byte_d, st_d, bom_d, dl_d;
  wire fifo_in_ready;
  wire g_byte = byte_pend;
  wire g_bom = bom_pend & ~byte_pend;
  wire g_dl = dl_pend & ~byte_pend & ~bom_pend;
  wire g_st = st_pend & ~byte_pend & ~bom_pend & ~dl_pend;
  wire fifo_in_valid = byte_pend | bom_pend | dl_pend | st_pend;
  wire [7:0] fifo_in_data = g_byte ? byte_d : g_bom ? bom_d : g_dl ? dl_d : st_d;
  wire tk = fifo_in_ready;

  rsh_fifo #(.W(8), .D(`RSH_FIFO_DEPTH), .AW(`RSH_FIFO_AW)) u_receive_fifo
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  reg [5:0] last_cw, acc_cw;
  reg [3:0] win_reg, eq_reg;
  reg [7:0] dlb_reg;
  reg [2:0] dlc_reg;
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      hsh_reg <= 8'h00;
      bsr_reg <= 8'h00;
      crc_reg <= `RSH_CRC_INIT;
      msh_reg <= 16'h0000;
      ones_reg <= 3'h0;
      bcnt_reg <= 3'h0;
      skip_reg <= 4'h0;
      run_reg <= 4'h0;
      bytes_reg <= 2'h0;
      in_frame_reg <= 1'b0;
      addr_ok_reg <= 1'b0;
      bom_reg <= 1'b0;
      byte_pend <= 1'b0;
      st_pend <= 1'b0;
      bom_pend <= 1'b0;
      dl_pend <= 1'b0;
      byte_d <= 8'h00;
      st_d <= 8'h00;
      bom_d <= 8'h00;
      dl_d <= 8'h00;
      last_cw <= 6'h00;
      acc_cw <= 6'h3f;
      win_reg <= 4'h0;
      eq_reg <= 4'h0;
      dlb_reg <= 8'h00;
      dlc_reg <= 3'h0;
      dl_bit_regs <= 24'h000000;
    end
    else
    begin
      // full fifo: newest word per source waits
      byte_pend <= byte_pend & ~(g_byte & tk);
      bom_pend <= bom_pend & ~(g_bom & tk);
      dl_pend <= dl_pend & ~(g_dl & tk);
      st_pend <= st_pend & ~(g_st & tk);
      if (hb_en)
      begin
        hsh_reg <= hsh_next;
        msh_reg <= msh_next;
        run_reg <= line_bit ? ((run_reg == 4'h8) ? run_reg : run_reg + 4'h1) : 4'h0;
        if (hdlc_receiver_on & message_receiver_on)
        begin
          if (~bom_reg & line_bit & (run_reg >= 4'h7))
            bom_reg <= 1'b1;
          else if (bom_reg & (hsh_next == `RSH_FLAG))
            bom_reg <= 1'b0;
        end
        else
          bom_reg <= message_receiver_on;
        if (skip_reg == 4'h0)
          ones_reg <= b_old ? ((ones_reg == 3'h7) ? ones_reg : ones_reg + 3'h1) : 3'h0;
        else if (~flag_seen)
          skip_reg <= skip_reg - 4'h1;
        if (dv)
        begin
          crc_reg <= crc_upd;
          bsr_reg <= byte_new;
          bcnt_reg <= bcnt_reg + 3'h1;
        end
        if (byte_done)
        begin
          if (bytes_reg != 2'h3)
            bytes_reg <= bytes_reg + 2'h1;
          if (bytes_reg == 2'h0)
            addr_ok_reg <= addr_now;
          if (byte_keep)
          begin
            byte_pend <= 1'b1;
            byte_d <= byte_new;
          end
        end
        if (flag_seen)
        begin
          if (in_frame_reg & (bytes_reg >= 2'h2) & addr_ok_reg)
          begin
            st_pend <= 1'b1;
            st_d <= {6'h00, bcnt_reg != 3'h0, crc_upd == `RSH_CRC_GOOD};
          end
          in_frame_reg <= 1'b1;
          skip_reg <= `RSH_FLAG_SKIP;
          ones_reg <= 3'h0;
          bcnt_reg <= 3'h0;
          bytes_reg <= 2'h0;
          crc_reg <= `RSH_CRC_INIT;
        end
        else if (abort_seen & ~transparent_mode)
          in_frame_reg <= 1'b0;
        if (cw_seen)
        begin
          win_reg <= (win_reg == `RSH_BOM_WIN) ? 4'h0 : win_reg + 4'h1;
          last_cw <= cw;
          eq_reg <= (win_reg == `RSH_BOM_WIN) ? 4'h1 : ((cw == last_cw) ? eq_reg + 4'h1 : 4'h1);
          if (message_filter_enable)
          begin
            if ((cw == last_cw) & (eq_reg + 4'h1 == `RSH_BOM_NEED) & (win_reg != `RSH_BOM_WIN))
            begin
              bom_pend <= 1'b1;
              bom_d <= {2'h0, cw};
            end
          end
          else if ((message_receive_mode == 2'h0) | ((message_receive_mode == 2'h1) & (cw != acc_cw)))
          begin
            bom_pend <= 1'b1;
            bom_d <= {2'h0, cw};
            acc_cw <= cw;
          end
        end
      end
      if (line_bit_en & f72_format & dl_bit)
      begin
        dl_bit_regs <= {dl_bit_regs[22:0], line_bit};
        if ((line_frame >= `RSH_DL_FIRST) & (line_frame <= `RSH_DL_LAST))
        begin
          dlb_reg <= {dlb_reg[6:0], line_bit};
          dlc_reg <= dlc_reg + 3'h1;
          if (dlc_reg == 3'h7)
          begin
            dl_pend <= 1'b1;
            dl_d <= {dlb_reg[6:0], line_bit};
          end
        end
        else
          dlc_reg <= 3'h0;
      end
    end
  end

  // robbed bit signaling store, freeze and change detection
  reg [95:0] sig_reg;
  reg freeze_reg;
  reg [1:0] cas_pos;
  reg cas_hit;
  always @*
  begin
    cas_hit = 1'b1;
    cas_pos = 2'h0;
    case (line_frame)
      7'd6: cas_pos = 2'h0;
      7'd12: cas_pos = 2'h1;
      7'd18: cas_pos = 2'h2;
      7'd24: cas_pos = 2'h3;
      default: cas_hit = 1'b0;
    endcase
  end
  wire cas_en = line_bit_en & (line_bitpos == 3'h7) & cas_hit & (line_ts <= `RSH_SIG_TS_MAX) & ~f72_format;
  wire cas_bit = ext_signaling_en ? ss_s2 : line_bit;
  wire [6:0] cas_idx = {line_ts[4:0], cas_pos};
  wire cas_chg = cas_en & ~freeze_reg & (sig_reg[cas_idx] != cas_bit);
  wire freeze_cause = ~auto_freeze_disable & (los | lfa | rx_slip);
  assign freeze_status_flag = freeze_reg;
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      sig_reg <= 96'h0;
      freeze_reg <= 1'b0;
      freeze_indicator_pin <= 1'b0;
      signaling_change_irq <= 1'b0;
      signaling_change_pointer <= 4'h0;
      sig_rd_data <= 8'h00;
    end
    else
    begin
      // freeze holds until a multiframe starts without a cause, or until auto freeze is disabled
      if (freeze_cause)
        freeze_reg <= 1'b1;
      else if (auto_freeze_disable | (line_bit_en & (line_frame == 7'h01) & (line_ts == 5'h00)))
        freeze_reg <= 1'b0;
      freeze_indicator_pin <= freeze_reg | freeze_cause;
      if (cas_en & ~freeze_reg)
        sig_reg[cas_idx] <= cas_bit;
      if (cas_chg)
      begin
        signaling_change_irq <= 1'b1;
        signaling_change_pointer <= line_ts[4:1];
      end
      else if (irq_status_read)
        signaling_change_irq <= 1'b0;
      if (sig_rd_index <= 4'hb)
        sig_rd_data <= sig_reg[{sig_rd_index, 3'h0} +: 8];
      else
        sig_rd_data <= 8'h00;
    end
  end

  // receive system highway
  wire [1:0] clk_code = highway_clock_rate_high ? 2'h3 : highway_clock_rate_low;
  wire [1:0] data_code = {highway_data_rate_high, highway_data_rate_low};
  assign rate_valid = (clk_code >= data_code) & (~multiplex_mode | (clk_code >= 2'h2)) &
    (~(multiplex_mode & byte_interleave) | (clk_code >= 2'h2));
  wire hc_rise = hc_s2 & ~hc_s3;
  wire hc_fall = ~hc_s2 & hc_s3;
  wire launch = highway_edge_select ? hc_fall : hc_rise;
  wire sync_start = ~sp_s2 & sp_s3;
  wire marker_mode = receive_pin_function == `RSH_PIN_MARKER;
  wire [11:0] offset = marker_mode ? 12'h000 : {receive_offset_high, receive_offset_low};
  reg [11:0] pos_reg;
  wire [11:0] frame_len = (12'h100 << clk_code) - 12'h001;
  wire [11:0] base12 = pos_reg >> clk_code;
  wire [7:0] base = base12[7:0];
  wire [11:0] sub = pos_reg & ((12'h001 << clk_code) - 12'h001);
  wire [11:0] phase12 = byte_interleave ? {9'h000, base[2:0]} : (sub >> (clk_code - data_code));
  wire phase_on = (phase12[2:0] == channel_phase_select) | (data_code == 2'h0 & ~multiplex_mode);
  assign highway_ts = base[7:3];
  wire [2:0] hbit = base[2:0];
  wire [1:0] ab_sel = (esf_format | hbit[1]) ? hbit[1:0] : {1'b0, hbit[0]};
  wire [6:0] rd_idx = {highway_ts, (esf_format ? hbit[1:0] : {1'b0, hbit[0]})};
  reg sig_bit;
  always @*
  begin
    sig_bit = 1'b1;
    if (highway_ts == 5'h00)
      sig_bit = highway_byte[3'h7 - hbit];
    else if (highway_ts_idle | (highway_ts > `RSH_SIG_TS_MAX))
      sig_bit = 1'b1;
    else if (~hbit[2])
      sig_bit = sig_fix_en ? sig_fix_val : 1'b1;
    else if (ab_sel != 2'h3 | esf_format)
      sig_bit = sig_reg[rd_idx];
  end
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      pos_reg <= 12'h000;
      receive_data_out <= 1'b0;
      receive_signaling_out <= 1'b0;
      receive_frame_marker <= 1'b0;
    end
    else if (launch)
    begin
      if (sync_start)
        pos_reg <= offset;
      else if (pos_reg >= frame_len)
        pos_reg <= 12'h000;
      else
        pos_reg <= pos_reg + 12'h001;
      receive_frame_marker <= marker_mode & (base == receive_offset_low);
      if (~phase_on)
      begin
        receive_data_out <= 1'b0;
        receive_signaling_out <= 1'b0;
      end
      else if (send_all_ones_system)
      begin
        receive_data_out <= 1'b1;
        receive_signaling_out <= 1'b1;
      end
      else
      begin
        receive_data_out <= highway_byte[3'h7 - hbit];
        receive_signaling_out <= sig_bit;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/rsh_rx_sig_highway_monitor.sv ====
// Purpose: port assertions of the highway block
// Assumes: one core clock domain, synchronous active high reset
// Notes: highway timing checked at base rate only
`timescale 1ns/100ps
`default_nettype none
module rsh_rx_sig_highway_monitor
(
  input wire logic clk, // core clock
  input wire logic sys_rst, // reset
  input wire logic los, // loss of signal
  input wire logic auto_freeze_disable, // no auto freeze
  input wire logic freeze_indicator_pin, // freeze pin
  input wire logic freeze_status_flag, // freeze status
  input wire logic line_bit_en, // line strobe
  input wire logic [4:0] line_ts, // line slot
  input wire logic irq_status_read, // status read
  input wire logic signaling_change_irq, // change pending
  input wire logic [3:0] signaling_change_pointer, // changed reg
  input wire logic fifo_out_valid, // fifo not empty
  input wire logic fifo_out_ready, // fifo pop
  input wire logic [7:0] fifo_out_data, // fifo head
  input wire logic [2:0] receive_pin_function, // pin function
  input wire logic receive_frame_marker, // marker
  input wire logic [1:0] highway_clock_rate_low, // clock code
  input wire logic highway_clock_rate_high, // top clock
  input wire logic highway_data_rate_high, // data msb
  input wire logic highway_data_rate_low, // data lsb
  input wire logic multiplex_mode, // multiplex
  input wire logic rate_valid, // rate ok
  input wire logic send_all_ones_system, // all ones
  input wire logic receive_data_out, // highway data
  input wire logic receive_signaling_out // highway signaling
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic [7:0] ones_cnt_reg;
  // covers sync lag and one bit
  always_ff @(posedge clk)
    if (sys_rst || !(send_all_ones_system && !multiplex_mode && !highway_data_rate_high && !highway_data_rate_low
        && !freeze_status_flag))
      ones_cnt_reg <= 8'h00;
    else if (ones_cnt_reg != 8'hff)
      ones_cnt_reg <= ones_cnt_reg + 8'h01;
  freeze_set_a: assert property ((los && !auto_freeze_disable) |=> freeze_indicator_pin ##[0:1] freeze_status_flag)
    else $error("no freeze after loss");
  no_freeze_a: assert property (auto_freeze_disable [*3] |=> !freeze_status_flag)
    else $error("freeze while disabled");
  irq_hold_a: assert property (signaling_change_irq && !irq_status_read |=> signaling_change_irq)
    else $error("irq dropped unread");
  irq_clear_a: assert property (irq_status_read && !line_bit_en |=> !signaling_change_irq)
    else $error("irq kept after read");
  irq_cause_a: assert property ($rose(signaling_change_irq) |-> $past(line_bit_en))
    else $error("irq without line bit");
  pointer_a: assert property ($rose(signaling_change_irq) |-> signaling_change_pointer == $past(line_ts) >> 1)
    else $error("pointer wrong");
  fifo_hold_a: assert property (fifo_out_valid && !fifo_out_ready |=> fifo_out_valid && $stable(fifo_out_data))
    else $error("fifo head lost");
  rate_check_a: assert property (rate_valid == ((highway_clock_rate_high ? 2'h3 : highway_clock_rate_low) >=
    {highway_data_rate_high, highway_data_rate_low} && (!multiplex_mode || highway_clock_rate_high
    || highway_clock_rate_low[1]))) else $error("rate valid wrong");
  all_ones_a: assert property (ones_cnt_reg == 8'hff |-> receive_data_out && receive_signaling_out)
    else $error("all ones missing");
  marker_mode_a: assert property ($rose(receive_frame_marker) |-> (receive_pin_function == 3'h1 && receive_frame_marker) [*8])
    else $error("marker wrong");
endmodule
bind rsh_rx_sig_highway rsh_rx_sig_highway_monitor rsh_rx_sig_highway_monitor_i (.*);
`default_nettype wire

// ==== tb/rsh_backplane_model.sv ====
// Purpose: highway clock and sync source
// Assumes: 160 ns clock, 256 clock frame
// Notes: start offset skews phase from clk
`timescale 1ns/100ps
`default_nettype none
module rsh_backplane_model
(
  output var logic receive_highway_clock, // highway clock
  output var logic receive_sync_pulse, // frame sync, low active
  output var logic system_signaling_in // external signaling pin
);
  int cnt = 0;
  initial
  begin
    receive_highway_clock = 1'b0;
    receive_sync_pulse = 1'b1;
    system_signaling_in = 1'b0;
    #7.3;
    forever #80 receive_highway_clock = ~receive_highway_clock;
  end
  // rising launch: both edges see settled data
  always @(posedge receive_highway_clock)
  begin
    cnt <= (cnt == 255) ? 0 : cnt + 1;
    receive_sync_pulse <= (cnt != 255);
    system_signaling_in <= 1'($urandom);
  end
endmodule
`default_nettype wire

// ==== tb/test_rsh_rx_sig_highway.sv ====
// Purpose: bench of the signaling highway block
// Assumes: inputs on falling edge
// Notes: all ones and frame marker checked here; other highway timing left to monitor
`timescale 1ns/100ps
`default_nettype none
module test_rsh_rx_sig_highway;
  logic clk = '0, sys_rst = '1;
  logic line_bit = '0, line_bit_en = '0, sig_slot = '0, dl_bit = '0, esf_format = '0, f72_format = '0;
  logic los = '0, lfa = '0, rx_slip = '0, hdlc_receiver_on = '0, message_receiver_on = '0, transparent_mode = '0;
  logic addr_two_byte = '0, message_filter_enable = '0, auto_freeze_disable = '0, ext_signaling_en = '0;
  logic send_all_ones_system = '0, sig_fix_en = '0, sig_fix_val = '0, irq_status_read = '0, fifo_out_ready = '0;
  logic highway_edge_select = '0, highway_clock_rate_high = '0, highway_data_rate_high = '0;
  logic highway_data_rate_low = '0, multiplex_mode = '0, byte_interleave = '0, highway_ts_idle = '0;
  logic [1:0] message_receive_mode = '0, highway_clock_rate_low = '0;
  logic [2:0] line_bitpos = '0, channel_phase_select = '0, receive_pin_function = '0;
  logic [3:0] sig_rd_index = '0, receive_offset_high = '0;
  logic [4:0] line_ts = '0;
  logic [6:0] line_frame = '0;
  logic [7:0] high_address_match_1 = '0, high_address_match_2 = '0, receive_offset_low = '0, highway_byte = '0;
  wire receive_highway_clock, receive_sync_pulse, system_signaling_in;
  wire freeze_indicator_pin, freeze_status_flag, signaling_change_irq, fifo_out_valid;
  wire receive_data_out, receive_signaling_out, receive_frame_marker, rate_valid;
  wire [3:0] signaling_change_pointer;
  wire [4:0] highway_ts;
  wire [7:0] sig_rd_data, fifo_out_data;
  wire [23:0] dl_bit_regs;
  int mismatches = 0, compares = 0, hi, rises;
  logic frz = '0, prev, bad;
  logic [95:0] st = '0;
  logic [23:0] sv;
  logic [7:0] q [64];
  rsh_rx_sig_highway rsh_rx_sig_highway_i (.*);
  rsh_backplane_model rsh_backplane_model_i (.*);
  initial
    forever #2 clk = ~clk;
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic b, input int ts, input int pos, input int fr, input logic s);
    {line_bit, line_ts, line_bitpos, line_frame, sig_slot} = {b, 5'(ts), 3'(pos), 7'(fr), s};
    line_bit_en = 1'b1;
    @(negedge clk) line_bit_en = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  // model store; frozen keeps old
  task automatic cas(input logic b, input int ts, input int pos, input int fr);
    send(b, ts, pos, fr, 1'b0);
    if (pos == 7 && fr % 6 == 0 && !frz)
      st[ts*4 + fr/6 - 1] = b;
  endtask
  task automatic cas_pass(input logic [23:0] v);
    for (int ts = 0; ts < 24; ts++)
    begin
      cas(v[ts], ts, 7, 6);
      cas(~v[ts], ts, 3, 6);
      cas(~v[ts], ts, 7, 5);
    end
  endtask
  task automatic rd_all();
    for (int k = 0; k < 12; k++)
    begin
      sig_rd_index = 4'(k);
      @(negedge clk);
      chk(sig_rd_data, st[8*k +: 8]);
    end
  endtask
  task automatic pulse_read();
    irq_status_read = 1'b1;
    @(negedge clk) irq_status_read = 1'b0;
    @(negedge clk);
  endtask
  function automatic logic exp_rate();
    int c = highway_clock_rate_high ? 3 : highway_clock_rate_low;
    int d = {highway_data_rate_high, highway_data_rate_low};
    return c >= d && (!multiplex_mode || c >= 2);
  endfunction
  // twice planned run
  initial
  begin
    repeat (80000) @(posedge clk);
    mismatches++;
    finish_test();
  end
  initial
  begin
    void'($urandom(40));
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    // flag passes as data
    {hdlc_receiver_on, transparent_mode} = 2'h3;
    {addr_two_byte, high_address_match_1, high_address_match_2} = 17'($urandom);
    for (int i = 0; i < 64; i++)
    begin
      q[i] = (i == 0) ? 8'h7e : 8'($urandom);
      for (int j = 0; j < 8; j++)
        send(q[i][j], 1, 0, 1, 1'b1);
    end
    repeat (4) @(negedge clk);
    for (int i = 0; i < 64; i++)
    begin
      chk({fifo_out_valid, fifo_out_data}, {1'b1, q[i]});
      fifo_out_ready = 1'b1;
      @(negedge clk) fifo_out_ready = 1'b0;
      @(negedge clk);
    end
    chk(fifo_out_valid, 1'b0);
    {hdlc_receiver_on, transparent_mode} = 2'h0;
    sv = 24'($urandom) | 24'h1;
    cas_pass(sv);
    chk(signaling_change_irq, 1'b1);
    pulse_read();
    chk(signaling_change_irq, 1'b0);
    cas_pass(sv);
    chk(signaling_change_irq, 1'b0);
    rd_all();
    cas(1'b1, 13, 7, 12);
    chk({signaling_change_irq, signaling_change_pointer}, {1'b1, 4'h6});
    pulse_read();
    for (int c = 0; c < 3; c++)
    begin
      {los, lfa, rx_slip} = 3'h4 >> c;
      @(negedge clk) rx_slip = 1'b0;
      @(negedge clk);
      chk({freeze_status_flag, freeze_indicator_pin}, 2'h3);
      frz = 1'b1;
      cas(~st[4], 1, 7, 6);
      {los, lfa, frz} = 3'h0;
      cas(1'b0, 0, 0, 1);
      repeat (2) @(negedge clk);
      chk(freeze_status_flag, 1'b0);
    end
    rd_all();
    {auto_freeze_disable, los} = 2'h3;
    repeat (4) @(negedge clk);
    chk(freeze_status_flag, 1'b0);
    cas(~st[4], 1, 7, 6);
    rd_all();
    {auto_freeze_disable, los} = 2'h0;
    pulse_read();
    for (int i = 0; i < 64; i++)
    begin
      {multiplex_mode, highway_clock_rate_high, highway_clock_rate_low, highway_data_rate_high,
        highway_data_rate_low} = 6'(i);
      @(negedge clk);
      chk(rate_valid, exp_rate());
    end
    {multiplex_mode, highway_clock_rate_high, highway_clock_rate_low, highway_data_rate_high,
      highway_data_rate_low} = 6'h0;
    {send_all_ones_system, sig_fix_en, sig_fix_val, highway_edge_select, highway_ts_idle, esf_format,
      f72_format, message_receiver_on} = {1'b1, 7'($urandom)};
    {channel_phase_select, receive_offset_high, receive_offset_low} = 15'($urandom);
    repeat (400) @(negedge clk);
    bad = 1'b0;
    repeat (2000)
    begin
      @(negedge clk) highway_byte = 8'($urandom);
      bad |= !(receive_data_out === 1'b1 && receive_signaling_out === 1'b1);
    end
    chk(bad, 1'b0);
    {send_all_ones_system, receive_pin_function} = 4'h1;
    repeat (11000) @(negedge clk);
    {hi, rises, prev} = '0;
    // two frames
    repeat (20480)
    begin
      @(negedge clk);
      hi += receive_frame_marker;
      rises += (receive_frame_marker && !prev);
      prev = receive_frame_marker;
    end
    chk(rises, 2);
    chk(hi >= 76 && hi <= 84, 1'b1);
    finish_test();
  end
endmodule
`default_nettype wire
